// ### logic/power_up_init_sequencer.sv
// Power-down release handling, register-access gating and PLL reset
// control for the bridge serializer.
// Assumes the control-bus slave hands over decoded byte accesses, and
// that the power-down release pin is already synchronous to MCLK_IN.
// Notes on behaviour
// - Clearing bit 5 at 0x5B stops link PLL reset on frequency change.
// - Writing 0x02 at 0x16 sets the shortened I2C glitch duration.
// - Bit 4 at 0x04 set suppresses video during blanking.
// - Register access is refused until 2 ms after the pin goes high.
// - Pin low for 2 ms hard-resets; shorter low pulses are ignored once ready, but any low during the ready wait resets.
// - 0x40, 0x41, 0x42 give paged access to pages 0x10 and 0x14.
// - Paged 0x49 bit 4 holds that PLL machine in reset; 3:0 zero.
`timescale 1ns/10ps
`default_nettype none
module power_up_init_sequencer #(
   parameter int READY_CYC    = pwrseq_pkg::READY_CYCLES,
   parameter int HARD_RST_CYC = pwrseq_pkg::HARD_RST_CYCLES
) (
   input  wire logic                   MCLK_IN,
   input  wire logic                   RST_N_IN,
   input  wire logic                   POWER_DOWN_RELEASE_PIN_IN,
   input  wire pwrseq_pkg::reg_req_t   REQ_IN,
   output logic                        ACK_OUT,
   output logic                        REFUSED_OUT,
   output logic      [7:0]             RDATA_OUT,
   output logic                        REG_READY_OUT,
   output logic                        DEVICE_RESET_OUT,
   output pwrseq_pkg::ctrl_out_t       CTRL_OUT
);
   import pwrseq_pkg::*;

   localparam int NREG = 6;
   localparam int CW   = 30;

   typedef enum {ST_OFF, ST_WAIT_READY, ST_RUN} pstate_t;

   pstate_t     state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic        hdmi_rst_reg, hdmi_rst_next;
   logic        link_rst_reg, link_rst_next;
   logic        ack_reg, ack_next;
   logic        ref_reg, ref_next;
   logic        paged_rd_reg, paged_rd_next;
   logic [7:0]  paged_data_reg, paged_data_next;
   logic [NREG-1:0]   wr_sel, rd_sel;
   logic [NREG*8-1:0] q, rst_vals;
   logic [7:0]  rf_rdata;
   logic        access_ok;
   logic        hdmi_sel, link_sel;

   initial begin
      if (READY_CYC < 1 || HARD_RST_CYC < 1 ||
          READY_CYC >= (1 << CW) || HARD_RST_CYC >= (1 << CW)) begin
         $error("Timing counts out of range");
      end
   end

   // Power-down pin filter and ready timer
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_OFF: begin
            cnt_next = '0;
            if (POWER_DOWN_RELEASE_PIN_IN) begin
               state_next = ST_WAIT_READY;
            end
         end
         ST_WAIT_READY: begin
            if (!POWER_DOWN_RELEASE_PIN_IN) begin
               state_next = ST_OFF;
            end else if (cnt_reg == CW'(READY_CYC - 1)) begin
               state_next = ST_RUN;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + CW'(1);
            end
         end
         ST_RUN: begin
            // A low pulse resets only once it has lasted the full time
            if (POWER_DOWN_RELEASE_PIN_IN) begin
               cnt_next = '0;
            end else if (cnt_reg == CW'(HARD_RST_CYC - 1)) begin
               state_next = ST_OFF;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + CW'(1);
            end
         end
         default: begin
            state_next = ST_OFF;
            cnt_next   = '0;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         state_reg <= ST_OFF;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign access_ok        = (state_reg == ST_RUN);
   assign DEVICE_RESET_OUT = (state_reg == ST_OFF);
   assign REG_READY_OUT    = access_ok;

   // Direct register decode; index order matches rst_vals packing
   always_comb begin
      wr_sel = '0;
      rd_sel = '0;
      case (REQ_IN.addr)
         BLANK_VIDEO_ADDR: rd_sel[0] = 1'b1;
         GLITCH_DUR_ADDR:  rd_sel[1] = 1'b1;
         IND_PAGE_ADDR:    rd_sel[2] = 1'b1;
         IND_OFFSET_ADDR:  rd_sel[3] = 1'b1;
         IND_DATA_ADDR:    rd_sel[4] = 1'b1;
         FREQ_RST_ADDR:    rd_sel[5] = 1'b1;
         default:          rd_sel    = '0;
      endcase
      if (access_ok && REQ_IN.wr) begin
         wr_sel = rd_sel;
      end
      if (!(access_ok && REQ_IN.rd)) begin
         rd_sel = '0;
      end
   end

   assign rst_vals = {FREQ_RST_RST, IND_RST, IND_RST, IND_RST,
                      GLITCH_DUR_RST, BLANK_VIDEO_RST};

   pwrseq_regfile #(
      .DEPTH (NREG)
   ) u_regs (
      .MCLK_IN    (MCLK_IN),
      .RST_N_IN   (RST_N_IN && !DEVICE_RESET_OUT),
      .WR_SEL_IN  (wr_sel),
      .WDATA_IN   (REQ_IN.wdata),
      .RST_VAL_IN (rst_vals),
      .RD_SEL_IN  (rd_sel),
      .Q_OUT      (q),
      .RDATA_OUT  (rf_rdata)
   );

   // Paged access through the data register
   assign hdmi_sel = (q[23:16] == HDMI_PAGE) &&
                     (q[31:24] == PLL_CTRL_OFFSET);
   assign link_sel = (q[23:16] == LINK_PAGE) &&
                     (q[31:24] == PLL_CTRL_OFFSET);

   always_comb begin
      hdmi_rst_next   = hdmi_rst_reg;
      link_rst_next   = link_rst_reg;
      ack_next        = (REQ_IN.wr || REQ_IN.rd) && access_ok;
      ref_next        = (REQ_IN.wr || REQ_IN.rd) && !access_ok;
      paged_rd_next   = access_ok && REQ_IN.rd &&
                        (REQ_IN.addr == IND_DATA_ADDR) &&
                        (hdmi_sel || link_sel);
      paged_data_next = PLL_CTRL_MASK &
                        {3'h0, hdmi_sel ? hdmi_rst_reg : link_rst_reg,
                         4'h0};
      if (access_ok && REQ_IN.wr && REQ_IN.addr == IND_DATA_ADDR) begin
         // Low nibble is ignored since it must be written as zero
         if (hdmi_sel) begin
            hdmi_rst_next = REQ_IN.wdata[SM_RESET_BIT];
         end
         if (link_sel) begin
            link_rst_next = REQ_IN.wdata[SM_RESET_BIT];
         end
      end
      if (DEVICE_RESET_OUT) begin
         hdmi_rst_next = 1'b0;
         link_rst_next = 1'b0;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         hdmi_rst_reg   <= 1'b0;
         link_rst_reg   <= 1'b0;
         ack_reg        <= 1'b0;
         ref_reg        <= 1'b0;
         paged_rd_reg   <= 1'b0;
         paged_data_reg <= 8'h00;
      end else begin
         hdmi_rst_reg   <= hdmi_rst_next;
         link_rst_reg   <= link_rst_next;
         ack_reg        <= ack_next;
         ref_reg        <= ref_next;
         paged_rd_reg   <= paged_rd_next;
         paged_data_reg <= paged_data_next;
      end
   end

   assign ACK_OUT     = ack_reg;
   assign REFUSED_OUT = ref_reg;
   assign RDATA_OUT   = paged_rd_reg ? paged_data_reg : rf_rdata;

   assign CTRL_OUT.freq_change_pll_reset_en     = q[40+FREQ_RST_BIT];
   assign CTRL_OUT.blank_video_suppress         = q[BLANK_SUPPRESS_BIT];
   assign CTRL_OUT.glitch_duration              = q[15:8];
   assign CTRL_OUT.hdmi_pll_state_machine_reset = hdmi_rst_reg;
   assign CTRL_OUT.link_pll_state_machine_reset = link_rst_reg;

   property no_early_access;
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (REQ_IN.wr && state_reg != ST_RUN) |=> !ACK_OUT && REFUSED_OUT;
   endproperty
   early_access_a: assert property (no_early_access)
      else $error("Access taken before ready time");

   hard_reset_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (state_reg == ST_RUN && (POWER_DOWN_RELEASE_PIN_IN ||
          cnt_reg != CW'(HARD_RST_CYC - 1))) |=> state_reg != ST_OFF)
      else $error("Reset without a long low pulse");

   sequence hdmi_page_write;
      access_ok && REQ_IN.wr && REQ_IN.addr == IND_DATA_ADDR && hdmi_sel
         && !DEVICE_RESET_OUT;
   endsequence
   hdmi_reset_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         hdmi_page_write |=>
            CTRL_OUT.hdmi_pll_state_machine_reset ==
               $past(REQ_IN.wdata[SM_RESET_BIT]))
      else $error("HDMI PLL reset bit not written");

   link_reset_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (access_ok && REQ_IN.wr && REQ_IN.addr == IND_DATA_ADDR &&
          link_sel) |=>
            CTRL_OUT.link_pll_state_machine_reset ==
               $past(REQ_IN.wdata[SM_RESET_BIT]))
      else $error("Link PLL reset bit not written");

   page_isolate_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (!hdmi_sel && !DEVICE_RESET_OUT) |=> $stable(hdmi_rst_reg))
      else $error("HDMI PLL bit changed without its page");

   freq_ctrl_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (access_ok && REQ_IN.wr && REQ_IN.addr == FREQ_RST_ADDR) |=>
            CTRL_OUT.freq_change_pll_reset_en ==
               $past(REQ_IN.wdata[FREQ_RST_BIT]))
      else $error("Frequency change control not updated");

   glitch_dur_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (access_ok && REQ_IN.wr && REQ_IN.addr == GLITCH_DUR_ADDR) |=>
            CTRL_OUT.glitch_duration == $past(REQ_IN.wdata))
      else $error("Glitch duration not updated");

   blank_supp_a: assert property (
      @(posedge MCLK_IN) disable iff (!RST_N_IN)
         (access_ok && REQ_IN.wr && REQ_IN.addr == BLANK_VIDEO_ADDR) |=>
            CTRL_OUT.blank_video_suppress ==
               $past(REQ_IN.wdata[BLANK_SUPPRESS_BIT]))
      else $error("Blanking suppression not updated");
endmodule
`default_nettype wire

// ### logic/pwrseq_pkg.sv
// Constants and types for the power-up and initialization sequencer.
// Assumes a 250 MHz core clock; register access arrives already decoded
// from the local control bus as an address, read and write strobes and data.
`default_nettype none
package pwrseq_pkg;
   localparam int          CLK_MHZ          = 250;
   localparam int          READY_TIME_MS    = 2;
   localparam int          HARD_RST_TIME_MS = 2;
   localparam int          READY_CYCLES     = READY_TIME_MS * 1000 * CLK_MHZ;
   localparam int          HARD_RST_CYCLES  = HARD_RST_TIME_MS * 1000 * CLK_MHZ;

   localparam logic [7:0]  BLANK_VIDEO_ADDR  = 8'h04;
   localparam logic [7:0]  GLITCH_DUR_ADDR   = 8'h16;
   localparam logic [7:0]  IND_PAGE_ADDR     = 8'h40;
   localparam logic [7:0]  IND_OFFSET_ADDR   = 8'h41;
   localparam logic [7:0]  IND_DATA_ADDR     = 8'h42;
   localparam logic [7:0]  FREQ_RST_ADDR     = 8'h5b;

   localparam logic [7:0]  HDMI_PAGE         = 8'h10;
   localparam logic [7:0]  LINK_PAGE         = 8'h14;
   localparam logic [7:0]  PLL_CTRL_OFFSET   = 8'h49;

   localparam int          SM_RESET_BIT      = 4;
   localparam int          FREQ_RST_BIT      = 5;
   localparam int          BLANK_SUPPRESS_BIT = 4;
   localparam logic [7:0]  PLL_CTRL_MASK     = 8'h10;

   // Reset values are not printed; these are chosen defaults
   localparam logic [7:0]  BLANK_VIDEO_RST   = 8'h00;
   localparam logic [7:0]  GLITCH_DUR_RST    = 8'h00;
   localparam logic [7:0]  FREQ_RST_RST      = 8'h20;
   localparam logic [7:0]  IND_RST           = 8'h00;
   localparam logic [7:0]  UNMAPPED_DATA     = 8'h00;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       freq_change_pll_reset_en;
      logic       blank_video_suppress;
      logic [7:0] glitch_duration;
      logic       hdmi_pll_state_machine_reset;
      logic       link_pll_state_machine_reset;
   } ctrl_out_t;
endpackage
`default_nettype wire

// ### logic/pwrseq_regfile.sv
// Small register store for the directly addressed control registers.
// Assumes writes are already qualified by the top; read data is registered.
`timescale 1ns/10ps
`default_nettype none
module pwrseq_regfile #(
   parameter int DEPTH = 6
) (
   input  wire logic                 MCLK_IN,
   input  wire logic                 RST_N_IN,
   input  wire logic [DEPTH-1:0]     WR_SEL_IN,
   input  wire logic [7:0]           WDATA_IN,
   input  wire logic [DEPTH*8-1:0]   RST_VAL_IN,
   input  wire logic [DEPTH-1:0]     RD_SEL_IN,
   output logic      [DEPTH*8-1:0]   Q_OUT,
   output logic      [7:0]           RDATA_OUT
);
   import pwrseq_pkg::*;

   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   initial begin
      if (DEPTH < 1) begin
         $error("DEPTH must be at least one");
      end
   end

   // Reset values arrive as package constants through the top
   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_word
         logic [7:0] word_reg;
         logic [7:0] word_next;
         always_comb begin
            word_next = word_reg;
            if (WR_SEL_IN[i]) begin
               word_next = WDATA_IN;
            end
         end
         always_ff @(posedge MCLK_IN) begin
            if (!RST_N_IN) begin
               word_reg <= RST_VAL_IN[i*8 +: 8];
            end else begin
               word_reg <= word_next;
            end
         end
         assign Q_OUT[i*8 +: 8] = word_reg;
      end
   endgenerate

   always_comb begin
      rdata_next = UNMAPPED_DATA;
      for (int k = 0; k < DEPTH; k++) begin
         if (RD_SEL_IN[k]) begin
            rdata_next = Q_OUT[k*8 +: 8];
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         rdata_reg <= UNMAPPED_DATA;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign RDATA_OUT = rdata_reg;
endmodule
`default_nettype wire

// ### test/pwrseq_host_model.sv
// Host controller model: drives the power-down release pin and decoded
// register requests. Assumes MCLK_IN is the sequencer's core clock.
`timescale 1ns/10ps
`default_nettype none
module pwrseq_host_model (
   input  wire logic            MCLK_IN,
   input  wire logic            ACK_IN,
   input  wire logic            REFUSED_IN,
   input  wire logic [7:0]      RDATA_IN,
   output logic                 PIN_OUT,
   output pwrseq_pkg::reg_req_t REQ_OUT
);
   import pwrseq_pkg::*;
   // Pin held low until supplies settle; request bus idle at start
   initial begin
      PIN_OUT = 1'b0;
      REQ_OUT = '0;
   end
   task automatic set_pin(input logic v);
      @(posedge MCLK_IN);
      #1 PIN_OUT = v;
   endtask
   // One-cycle request; the answer is taken one edge later
   task automatic access(input logic w, input logic [7:0] a, d,
                         output logic [1:0] resp, output logic [7:0] q);
      @(posedge MCLK_IN);
      #1 REQ_OUT = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge MCLK_IN);
      #1 REQ_OUT = '0;
      resp = {ACK_IN, REFUSED_IN};
      q = RDATA_IN;
   endtask
endmodule
`default_nettype wire

// ### test/power_up_init_sequencer_tb.sv
// Self-checking bench for the power-up sequencer with short counts.
// Assumes the host model above is the only driver of pin and requests.
`timescale 1ns/10ps
`default_nettype none
module power_up_init_sequencer_tb;
   import pwrseq_pkg::*;
   localparam int RDY = 20;
   localparam int HRD = 10;
   // One microsecond of stable input clock at the 4 ns core period
   localparam int TMDS_SETTLE = 250;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        pin;
   reg_req_t    req;
   logic        ack, refused, ready, dev_rst;
   logic [7:0]  rdata;
   ctrl_out_t   ctrl;
   int          failures = 0;
   int          check_count = 0;
   logic [1:0]  resp;
   logic [7:0]  q;

   always #2 mclk = ~mclk;

   power_up_init_sequencer #(.READY_CYC(RDY), .HARD_RST_CYC(HRD))
   power_up_init_sequencer_i (
      .MCLK_IN                   (mclk),
      .RST_N_IN                  (rst_n),
      .POWER_DOWN_RELEASE_PIN_IN (pin),
      .REQ_IN                    (req),
      .ACK_OUT                   (ack),
      .REFUSED_OUT               (refused),
      .RDATA_OUT                 (rdata),
      .REG_READY_OUT             (ready),
      .DEVICE_RESET_OUT          (dev_rst),
      .CTRL_OUT                  (ctrl)
   );
   pwrseq_host_model pwrseq_host_model_i (
      .MCLK_IN    (mclk),
      .ACK_IN     (ack),
      .REFUSED_IN (refused),
      .RDATA_IN   (rdata),
      .PIN_OUT    (pin),
      .REQ_OUT    (req)
   );

   task automatic chk(input string n, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      pwrseq_host_model_i.access(1'b1, a, d, resp, q);
      chk("write response", 8'h02, {6'h00, resp});
   endtask
   task automatic rd(input logic [7:0] a, e);
      pwrseq_host_model_i.access(1'b0, a, 8'h00, resp, q);
      chk("read response", 8'h02, {6'h00, resp});
      chk("read data", e, q);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Release pin and measure the ready delay
   task automatic t_power_up;
      int n;
      pwrseq_host_model_i.access(1'b1, GLITCH_DUR_ADDR, 8'h02, resp, q);
      chk("early access", 8'h01, {6'h00, resp});
      chk("held in reset", 8'h01, {7'h00, dev_rst});
      pwrseq_host_model_i.set_pin(1'b1);
      pwrseq_host_model_i.access(1'b0, FREQ_RST_ADDR, 8'h00, resp, q);
      chk("waiting access", 8'h01, {6'h00, resp});
      n = 2;
      while (ready !== 1'b1 && n < 60) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("ready delay ok", 8'h01, {7'h00, n >= RDY && n <= RDY + 2});
   endtask
   task automatic t_seq_a;
      rd(FREQ_RST_ADDR, FREQ_RST_RST);
      chk("freq reset en", 8'h01, {7'h00, ctrl.freq_change_pll_reset_en});
      wr(FREQ_RST_ADDR, 8'h00);
      wr(GLITCH_DUR_ADDR, 8'h02);
      wr(BLANK_VIDEO_ADDR, 8'h10);
      chk("freq reset off", 8'h00, {7'h00, ctrl.freq_change_pll_reset_en});
      chk("glitch dur", 8'h02, ctrl.glitch_duration);
      chk("blank supp", 8'h01, {7'h00, ctrl.blank_video_suppress});
      rd(GLITCH_DUR_ADDR, 8'h02);
      rd(BLANK_VIDEO_ADDR, 8'h10);
   endtask
   task automatic t_seq_b;
      logic [7:0] pg [2] = '{HDMI_PAGE, LINK_PAGE};
      // Input clock counts as stable from here; wait before the PLL resets
      repeat (TMDS_SETTLE) @(posedge mclk);
      foreach (pg[i]) begin
         wr(IND_PAGE_ADDR, pg[i]);
         wr(IND_OFFSET_ADDR, PLL_CTRL_OFFSET);
         wr(IND_DATA_ADDR, 8'h10);
         chk("pll resets", {6'h00, i == 0, i == 1},
             {6'h00, ctrl.hdmi_pll_state_machine_reset,
              ctrl.link_pll_state_machine_reset});
         rd(IND_DATA_ADDR, 8'h10);
         wr(IND_DATA_ADDR, 8'h00);
         chk("pll released", 8'h00,
             {6'h00, ctrl.hdmi_pll_state_machine_reset,
              ctrl.link_pll_state_machine_reset});
      end
      rd(IND_PAGE_ADDR, LINK_PAGE);
      wr(IND_OFFSET_ADDR, 8'h00);
      wr(IND_DATA_ADDR, 8'h10);
      chk("unpaged write", 8'h00,
          {6'h00, ctrl.hdmi_pll_state_machine_reset,
           ctrl.link_pll_state_machine_reset});
      rd(IND_DATA_ADDR, 8'h10);
      wr(8'h7f, 8'h55);
      rd(8'h7f, UNMAPPED_DATA);
   endtask
   // A low pulse shorter than the hard-reset time must be ignored
   task automatic t_short_low;
      pwrseq_host_model_i.set_pin(1'b0);
      repeat (HRD - 3) @(posedge mclk);
      pwrseq_host_model_i.set_pin(1'b1);
      chk("short low rst", 8'h00, {7'h00, dev_rst});
      rd(GLITCH_DUR_ADDR, 8'h02);
   endtask
   task automatic t_hard_reset;
      pwrseq_host_model_i.set_pin(1'b0);
      repeat (HRD + 3) @(posedge mclk);
      #1 chk("hard reset", 8'h01, {7'h00, dev_rst});
      chk("not ready", 8'h00, {7'h00, ready});
      t_power_up();
      rd(GLITCH_DUR_ADDR, GLITCH_DUR_RST);
      rd(BLANK_VIDEO_ADDR, BLANK_VIDEO_RST);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      #1 rst_n = 1'b1;
      t_power_up();
      t_seq_a();
      t_seq_b();
      t_short_low();
      t_hard_reset();
      summarize();
   end
   // Whole run is well under a thousand cycles
   initial begin
      #20000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
